// ==== core/scp_consts.svh ====
// Purpose: Offsets, field positions, reset values and counts of the port
// Assumes: Included by bare name wherever needed
// Notes: Definitions only
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

`define SCP_ADDR_IF_CFG 5'h17
`define SCP_ADDR_PHASE_LOW 5'h1D
`define SCP_ADDR_PHASE_GAIN_HIGH 5'h1E
`define SCP_ADDR_ALARM_REV 5'h1F

`define SCP_FOUR_WIRE_BIT 2
`define SCP_PHASE_HI_MSB 7
`define SCP_PHASE_HI_LSB 6
`define SCP_GAIN_A_MSB 5
`define SCP_GAIN_A_LSB 3
`define SCP_GAIN_B_MSB 2
`define SCP_GAIN_B_LSB 0
`define SCP_CLK_ALARM_BIT 7
`define SCP_TX_OFF_BIT 6

`define SCP_RST_IF_CFG 1'b0
`define SCP_RST_PHASE_LOW 8'h00
`define SCP_RST_PHASE_GAIN_HIGH 8'h24

`define SCP_INSTR_RW_BIT 7
`define SCP_INSTR_CNT_MSB 6
`define SCP_INSTR_CNT_LSB 5
`define SCP_INSTR_ADDR_MSB 4

`define SCP_DCLK_STOP_CYCLES 4
`define SCP_PHASE_FRAC_BITS 12
`define SCP_SYNC_STAGES 3

`endif

// ==== core/scp_pkg.sv ====
// Purpose: Types shared by the serial control port files
// Assumes: Used only as scp_pkg::name
// Notes: Constants live in scp_consts.svh
package scp_pkg;

   typedef enum logic [1:0] {
      ST_INSTR,
      ST_DATA,
      ST_DONE
   } scp_frame_t;

   typedef struct packed {
      logic [9:0] phase;
      logic [2:0] gain_a_high;
      logic [2:0] gain_b_high;
   } scp_qmc_t;

   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } scp_sample_t;

endpackage

// ==== core/scp_phase_corr.sv ====
// Purpose: IQ phase correction and output muting
// Assumes: Samples arrive every clk, two's complement
// Notes: Mid-level output is code zero
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_phase_corr (
   input wire logic clk,
   input wire logic srst,
   input wire scp_pkg::scp_sample_t sample_in,
   input wire logic [9:0] phase,
   input wire logic mute,
   output scp_pkg::scp_sample_t sample_out
);

   logic signed [25:0] prod;
   logic signed [17:0] corr;
   logic signed [17:0] sum;
   logic signed [15:0] i_sat;
   scp_pkg::scp_sample_t out_d;
   scp_pkg::scp_sample_t out_q;

   always_comb begin
      // Phase scaled by 2^-12 spans -0.125 to 0.12475
      prod = $signed(phase) * sample_in.q;
      corr = {{4{prod[25]}}, prod[25:`SCP_PHASE_FRAC_BITS]};
      sum = {{2{sample_in.i[15]}}, sample_in.i} + corr;
      if (sum > 18'sd32767) begin
         i_sat = 16'sh7FFF;
      end else if (sum < -18'sd32768) begin
         i_sat = 16'sh8000;
      end else begin
         i_sat = sum[15:0];
      end
      out_d.i = i_sat;
      out_d.q = sample_in.q;
      if (mute) begin
         out_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign sample_out = out_q;

endmodule

// ==== core/scp_regs.sv ====
// Purpose: Serial control port with QMC phase/gain and clock alarm regs
// Assumes: sclk runs only inside frames; srst held over some sclk edges
// Notes: Register file lives on sclk, alarm and datapath on clk
`timescale 1ns/1ps
`include "scp_consts.svh"

// Functional notes
// - Phase word is ten bits: low byte at 0x1D, top two in 0x1E.
// - Phase word is two's complement spanning -0.125 to 0.12475, reset zero.
// - Corrected I is I plus phase word times current Q.
// - Channel A gain top bits sit in 0x1E 5:3, reset 100.
// - Channel B gain top bits sit in 0x1E 2:0, reset 100.
// - Clock-stopped flag sets after four idle data clocks; cleared by zero.
// - Alarm sets muted flag and forces mid-level; cleared by zero.
// - Revision field in 0x1F 5:0 is hardwired and read-only.
// - Four-wire select bit chooses 3-pin or 4-pin port.
// - 3-pin reads on data pin; 4-pin reads on alarm pin.
// - Serial input sampled on rising serial clock edges.
// - First byte is instruction; following bytes are data.
// - Instruction bit 7 high reads, low writes.
// - Instruction bits 6:5 give one to four data bytes.
// - All bytes shift most significant bit first.
// - Low five instruction bits give the starting register address.
// - Address decrements by one after each data byte.
// - 4-pin read drives low after last byte until enable rises.
module scp_regs #(
   parameter logic [5:0] REVISION = 6'h21, // Arbitrary value
   parameter int DCLK_PERIOD_CLKS = 4,
   parameter int STOP_CNT_W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic serial_enable_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic alarm_serial_out_pin_o,
   output logic alarm_serial_out_pin_oe,
   input wire logic input_data_clock,
   input wire scp_pkg::scp_sample_t sample_in,
   output scp_pkg::scp_sample_t sample_out,
   output logic [2:0] gain_a_high,
   output logic [2:0] gain_b_high,
   output logic output_muted,
   output logic clock_alarm
);

   localparam int STOP_LIMIT = `SCP_DCLK_STOP_CYCLES * DCLK_PERIOD_CLKS;
   localparam logic [STOP_CNT_W-1:0] STOP_LAST =
      STOP_CNT_W'(STOP_LIMIT - 1);
   localparam int NS = `SCP_SYNC_STAGES;

   // Serial clock domain state
   logic [NS-1:0] rst_sync_q;
   logic [NS-1:0] rst_sync_d;
   logic [NS-1:0] alm_sync_q;
   logic [NS-1:0] alm_sync_d;
   logic [NS-1:0] mut_sync_q;
   logic [NS-1:0] mut_sync_d;
   logic rst_s;

   scp_pkg::scp_frame_t state_q;
   scp_pkg::scp_frame_t state_d;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic [6:0] sh_q;
   logic [6:0] sh_d;
   logic rw_q;
   logic rw_d;
   logic [1:0] left_q;
   logic [1:0] left_d;
   logic [4:0] addr_q;
   logic [4:0] addr_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic [7:0] byte_in;
   logic wr_en;

   logic four_wire_select_q;
   logic four_wire_select_d;
   logic [7:0] phase_low_q;
   logic [7:0] phase_low_d;
   logic [7:0] phase_gain_high_q;
   logic [7:0] phase_gain_high_d;
   logic cfg_tgl_q;
   logic cfg_tgl_d;
   logic clr_alm_tgl_q;
   logic clr_alm_tgl_d;
   logic clr_mut_tgl_q;
   logic clr_mut_tgl_d;

   logic out_q;
   logic out_d;
   logic drive_q;
   logic drive_d;

   // System clock domain state
   logic [3:0] sync_q [NS];
   logic [3:0] sync_d [NS];
   logic [3:0] evt;
   logic [STOP_CNT_W-1:0] stop_cnt_q;
   logic [STOP_CNT_W-1:0] stop_cnt_d;
   logic alarm_q;
   logic alarm_d;
   logic muted_q;
   logic muted_d;
   logic alarm_set;
   scp_pkg::scp_qmc_t qmc_q;
   scp_pkg::scp_qmc_t qmc_d;

   // Register read decode, used for first and later bytes
   function automatic logic [7:0] read_reg(
      input logic [4:0] a,
      input logic fw,
      input logic [7:0] plo,
      input logic [7:0] phi,
      input logic alm,
      input logic mut
   );
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         `SCP_ADDR_IF_CFG: r[`SCP_FOUR_WIRE_BIT] = fw;
         `SCP_ADDR_PHASE_LOW: r = plo;
         `SCP_ADDR_PHASE_GAIN_HIGH: r = phi;
         `SCP_ADDR_ALARM_REV: r = {alm, mut, REVISION};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Reset and flag synchronisers on serial clock
   always_comb begin
      rst_sync_d = {rst_sync_q[NS-2:0], srst};
      alm_sync_d = {alm_sync_q[NS-2:0], alarm_q};
      mut_sync_d = {mut_sync_q[NS-2:0], muted_q};
   end

   always_ff @(posedge sclk) begin
      rst_sync_q <= rst_sync_d;
      alm_sync_q <= alm_sync_d;
      mut_sync_q <= mut_sync_d;
   end

   assign rst_s = rst_sync_q[NS-1];

   // Frame sequencer
   always_comb begin
      byte_in = {sh_q, sdio_i};
      sh_d = {sh_q[5:0], sdio_i};
      cnt_d = cnt_q + 3'h1;
      state_d = state_q;
      rw_d = rw_q;
      left_d = left_q;
      addr_d = addr_q;
      tx_d = tx_q;
      wr_en = 1'b0;
      if (cnt_q == 3'h7) begin
         unique case (state_q)
            scp_pkg::ST_INSTR: begin
               rw_d = byte_in[`SCP_INSTR_RW_BIT];
               left_d =
                  byte_in[`SCP_INSTR_CNT_MSB:`SCP_INSTR_CNT_LSB];
               addr_d = byte_in[`SCP_INSTR_ADDR_MSB:0];
               tx_d = read_reg(byte_in[`SCP_INSTR_ADDR_MSB:0],
                  four_wire_select_q, phase_low_q, phase_gain_high_q,
                  alm_sync_q[NS-1], mut_sync_q[NS-1]);
               state_d = scp_pkg::ST_DATA;
            end
            scp_pkg::ST_DATA: begin
               wr_en = !rw_q;
               addr_d = addr_q - 5'h01;
               tx_d = read_reg(addr_q - 5'h01, four_wire_select_q,
                  phase_low_q, phase_gain_high_q,
                  alm_sync_q[NS-1], mut_sync_q[NS-1]);
               if (left_q == 2'h0) begin
                  state_d = scp_pkg::ST_DONE;
               end else begin
                  left_d = left_q - 2'h1;
               end
            end
            scp_pkg::ST_DONE: begin
               state_d = scp_pkg::ST_DONE;
            end
         endcase
      end
   end

   // Enable high ends any frame at once
   always_ff @(posedge sclk or posedge serial_enable_n) begin
      if (serial_enable_n) begin
         state_q <= scp_pkg::ST_INSTR;
         cnt_q <= 3'h0;
         sh_q <= 7'h00;
         rw_q <= 1'b0;
         left_q <= 2'h0;
         addr_q <= 5'h00;
         tx_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rw_q <= rw_d;
         left_q <= left_d;
         addr_q <= addr_d;
         tx_q <= tx_d;
      end
   end

   // Register writes
   always_comb begin
      four_wire_select_d = four_wire_select_q;
      phase_low_d = phase_low_q;
      phase_gain_high_d = phase_gain_high_q;
      cfg_tgl_d = cfg_tgl_q;
      clr_alm_tgl_d = clr_alm_tgl_q;
      clr_mut_tgl_d = clr_mut_tgl_q;
      if (wr_en) begin
         unique case (addr_q)
            `SCP_ADDR_IF_CFG: begin
               four_wire_select_d = byte_in[`SCP_FOUR_WIRE_BIT];
            end
            `SCP_ADDR_PHASE_LOW: begin
               phase_low_d = byte_in;
               cfg_tgl_d = !cfg_tgl_q;
            end
            `SCP_ADDR_PHASE_GAIN_HIGH: begin
               phase_gain_high_d = byte_in;
               cfg_tgl_d = !cfg_tgl_q;
            end
            `SCP_ADDR_ALARM_REV: begin
               // Only zeros act; revision bits dropped
               if (!byte_in[`SCP_CLK_ALARM_BIT]) begin
                  clr_alm_tgl_d = !clr_alm_tgl_q;
               end
               if (!byte_in[`SCP_TX_OFF_BIT]) begin
                  clr_mut_tgl_d = !clr_mut_tgl_q;
               end
            end
            default: begin
               four_wire_select_d = four_wire_select_q;
            end
         endcase
      end
   end

   always_ff @(posedge sclk) begin
      if (rst_s) begin
         four_wire_select_q <= `SCP_RST_IF_CFG;
         phase_low_q <= `SCP_RST_PHASE_LOW;
         phase_gain_high_q <= `SCP_RST_PHASE_GAIN_HIGH;
         cfg_tgl_q <= 1'b0;
         clr_alm_tgl_q <= 1'b0;
         clr_mut_tgl_q <= 1'b0;
      end else begin
         four_wire_select_q <= four_wire_select_d;
         phase_low_q <= phase_low_d;
         phase_gain_high_q <= phase_gain_high_d;
         cfg_tgl_q <= cfg_tgl_d;
         clr_alm_tgl_q <= clr_alm_tgl_d;
         clr_mut_tgl_q <= clr_mut_tgl_d;
      end
   end

   // Read data launched on falling edges
   always_comb begin
      out_d = 1'b0;
      drive_d = 1'b0;
      if (rw_q && state_q == scp_pkg::ST_DATA) begin
         out_d = tx_q[~cnt_q];
         drive_d = 1'b1;
      end else if (rw_q && state_q == scp_pkg::ST_DONE) begin
         out_d = 1'b0;
         drive_d = four_wire_select_q;
      end
   end

   always_ff @(negedge sclk or posedge serial_enable_n) begin
      if (serial_enable_n) begin
         out_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         out_q <= out_d;
         drive_q <= drive_d;
      end
   end

   // Pin steering by port width
   assign sdio_o = out_q;
   assign sdio_oe = !serial_enable_n && drive_q &&
      !four_wire_select_q;
   assign alarm_serial_out_pin_o = out_q;
   assign alarm_serial_out_pin_oe = !serial_enable_n && drive_q &&
      four_wire_select_q;

   // Crossings into clk: data clock and three toggles
   always_comb begin
      sync_d[0] = {clr_mut_tgl_q, clr_alm_tgl_q, cfg_tgl_q,
         input_data_clock};
      for (int k = 1; k < NS; k++) begin
         sync_d[k] = sync_q[k-1];
      end
   end

   always_ff @(posedge clk) begin
      for (int k = 0; k < NS; k++) begin
         if (srst) begin
            sync_q[k] <= 4'h0;
         end else begin
            sync_q[k] <= sync_d[k];
         end
      end
   end

   assign evt = sync_q[NS-2] ^ sync_q[NS-1];

   // Stopped data clock watchdog and sticky flags
   always_comb begin
      stop_cnt_d = stop_cnt_q;
      alarm_set = 1'b0;
      if (evt[0]) begin
         stop_cnt_d = '0;
      end else if (stop_cnt_q != STOP_LAST) begin
         stop_cnt_d = stop_cnt_q + STOP_CNT_W'(1);
         alarm_set = (stop_cnt_q == STOP_LAST - STOP_CNT_W'(1));
      end
      // Set beats a clear in the same cycle
      alarm_d = alarm_set || (alarm_q && !evt[2]);
      muted_d = alarm_set || (muted_q && !evt[3]);
      qmc_d = qmc_q;
      if (evt[1]) begin
         qmc_d.phase = {phase_gain_high_q[`SCP_PHASE_HI_MSB:
            `SCP_PHASE_HI_LSB], phase_low_q};
         qmc_d.gain_a_high =
            phase_gain_high_q[`SCP_GAIN_A_MSB:`SCP_GAIN_A_LSB];
         qmc_d.gain_b_high =
            phase_gain_high_q[`SCP_GAIN_B_MSB:`SCP_GAIN_B_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         stop_cnt_q <= '0;
         alarm_q <= 1'b0;
         muted_q <= 1'b0;
         qmc_q.phase <= 10'h000;
         qmc_q.gain_a_high <= 3'h4;
         qmc_q.gain_b_high <= 3'h4;
      end else begin
         stop_cnt_q <= stop_cnt_d;
         alarm_q <= alarm_d;
         muted_q <= muted_d;
         qmc_q <= qmc_d;
      end
   end

   assign gain_a_high = qmc_q.gain_a_high;
   assign gain_b_high = qmc_q.gain_b_high;
   assign output_muted = muted_q;
   assign clock_alarm = alarm_q;

   scp_phase_corr u_phase_corr (
      .clk(clk),
      .srst(srst),
      .sample_in(sample_in),
      .phase(qmc_q.phase),
      .mute(muted_q),
      .sample_out(sample_out)
   );

endmodule

// ==== sim/scp_regs_sva.sv ====
// Purpose: Port checks of the serial control port
// Assumes: Bound to scp_regs
// Notes: All checks run on clk
`timescale 1ns/1ps
module scp_regs_sva #(
   parameter int DCLK_PERIOD_CLKS = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic serial_enable_n,
   input wire logic sdio_i,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   input wire logic alarm_serial_out_pin_o,
   input wire logic alarm_serial_out_pin_oe,
   input wire logic input_data_clock,
   input wire scp_pkg::scp_sample_t sample_in,
   input wire scp_pkg::scp_sample_t sample_out,
   input wire logic [2:0] gain_a_high,
   input wire logic [2:0] gain_b_high,
   input wire logic output_muted,
   input wire logic clock_alarm
);
   localparam int LIM = 4 * DCLK_PERIOD_CLKS + 10;
   localparam int MIN = 4 * DCLK_PERIOD_CLKS;
   logic [15:0] idle_q, idle_d;
   logic dk_q;
   default clocking dcb @(posedge clk); endclocking
   default disable iff (srst);
   // Cycles since the data clock last moved
   always_comb begin
      idle_d = idle_q + 16'h0001;
      if (input_data_clock != dk_q) begin
         idle_d = 16'h0000;
      end else if (idle_q == 16'hFFFF) begin
         idle_d = idle_q;
      end
   end
   always_ff @(posedge clk) begin
      dk_q <= input_data_clock;
      if (srst) begin
         idle_q <= 16'h0000;
      end else begin
         idle_q <= idle_d;
      end
   end
   a_oe_exclusive: assert property (!(sdio_oe && alarm_serial_out_pin_oe))
      else $error("both data pins driven");
   a_oe_idle: assert property (serial_enable_n |->
      !sdio_oe && !alarm_serial_out_pin_oe && !sdio_o &&
      !alarm_serial_out_pin_o)
      else $error("pin driven outside frame");
   a_oe_release: assert property ($fell(alarm_serial_out_pin_oe) |->
      serial_enable_n)
      else $error("serial out released early");
   a_mute_zero: assert property (output_muted |=>
      sample_out == 32'h0000_0000)
      else $error("muted output not mid-level");
   a_q_pass: assert property (!output_muted |=>
      sample_out.q == $past(sample_in.q))
      else $error("q sample altered");
   a_gain_reset: assert property ($fell(srst) |->
      gain_a_high == 3'h4 && gain_b_high == 3'h4)
      else $error("gain reset value wrong");
   a_alarm_stop: assert property (idle_q == LIM |-> clock_alarm)
      else $error("stopped clock not flagged");
   a_alarm_early: assert property ($rose(clock_alarm) |-> idle_q >= MIN)
      else $error("clock flag set too early");
   a_flags_pair: assert property ($rose(clock_alarm) |-> output_muted)
      else $error("mute flag not set with alarm");
endmodule

// ==== sim/scp_host.sv ====
// Purpose: Host serial master driving frames
// Assumes: sclk idles low and stands still between frames
// Notes: Released data line shows inverse of last level
`timescale 1ns/1ps
module scp_host (
   output logic sclk,
   output logic serial_enable_n,
   output logic sdio_i,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   input wire logic alarm_serial_out_pin_o,
   input wire logic alarm_serial_out_pin_oe
);
   logic drv, bit_q, last_q;
   logic [1:0] tail;
   logic [31:0] rdata;
   event got;
   wire aw = alarm_serial_out_pin_oe ? alarm_serial_out_pin_o : ~last_q;
   initial begin
      sclk = 0;
      serial_enable_n = 1;
      drv = 1;
      bit_q = 0;
      last_q = 0;
      tail = 0;
      rdata = 0;
   end
   always @(sclk) last_q <= sdio_i;
   always_comb begin
      if (sdio_oe) sdio_i = sdio_o;
      else if (drv) sdio_i = bit_q;
      else sdio_i = ~last_q;
   end
   task automatic idle(input int n);
      repeat (n) begin
         #15 sclk = 1;
         #15 sclk = 0;
      end
   endtask
   task automatic xfer(input logic rd, input logic [1:0] n,
      input logic [4:0] a, input logic [31:0] wd, input logic fw);
      logic [39:0] sh;
      #7 sh = {rd, n, a, wd};
      rdata = 0;
      serial_enable_n = 0;
      for (int k = 0; k < 16 + 8 * n; k++) begin
         drv = !rd || k < 8;
         bit_q = sh[39-k];
         #15 sclk = 1;
         if (k >= 8) rdata = {rdata[30:0], fw ? aw : sdio_i};
         #15 sclk = 0;
      end
      #15 tail = {alarm_serial_out_pin_oe, aw};
      if (rd) -> got;
      serial_enable_n = 1;
      drv = 1;
      #15;
   endtask
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench of the serial control port
// Assumes: Host model makes the serial clock
// Notes: Reads are scored from a queue of expected read words
`timescale 1ns/1ps
module testbench;
   localparam int DCLK = 2;
   localparam logic [5:0] REV = 6'h2A; // Arbitrary value
   logic clk, srst, input_data_clock, dclk_run, fw;
   logic sclk, sen_n, sdio_i, sdio_o, sdio_oe, ao, aoe;
   logic output_muted, clock_alarm;
   logic [2:0] gain_a_high, gain_b_high;
   logic [15:0] lfsr;
   logic [31:0] exp_q[$];
   scp_pkg::scp_sample_t sample_in, sample_out;
   int num_errors, checks, cyc;
   scp_regs #(.REVISION(REV), .DCLK_PERIOD_CLKS(DCLK)) dut (.clk(clk),
      .srst(srst), .sclk(sclk), .serial_enable_n(sen_n), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .alarm_serial_out_pin_o(ao),
      .alarm_serial_out_pin_oe(aoe), .input_data_clock(input_data_clock),
      .sample_in(sample_in), .sample_out(sample_out),
      .gain_a_high(gain_a_high), .gain_b_high(gain_b_high),
      .output_muted(output_muted), .clock_alarm(clock_alarm));
   scp_host host (.sclk(sclk), .serial_enable_n(sen_n), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .alarm_serial_out_pin_o(ao),
      .alarm_serial_out_pin_oe(aoe));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] corr(input logic [15:0] i, q,
      input logic [9:0] p);
      logic signed [31:0] s;
      s = $signed(i) + (($signed(p) * $signed(q)) >>> 12);
      if (s > 32767) return 16'h7FFF;
      if (s < -32768) return 16'h8000;
      return s[15:0];
   endfunction
   task automatic chk(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task automatic stop_test;
      if (exp_q.size() != 0) num_errors++;
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [1:0] n, input logic [4:0] a,
      input logic [31:0] e);
      exp_q.push_back(e);
      host.xfer(1, n, a, 32'h0000_0000, fw);
   endtask
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (dclk_run) input_data_clock <= #1 ~input_data_clock;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         stop_test;
      end
   end
   always begin
      @(host.got);
      chk(host.rdata, exp_q.pop_front());
   end
   initial begin
      logic [9:0] ph;
      logic [2:0] ga, gb;
      scp_pkg::scp_sample_t ex;
      srst = 1;
      dclk_run = 1;
      input_data_clock = 0;
      sample_in = 0;
      fw = 0;
      lfsr = 16'h004C;
      num_errors = 0;
      checks = 0;
      cyc = 0;
      host.idle(6);
      cw(1);
      srst = 0;
      host.idle(5);
      rd(2'b10, 5'h1F, {8'h00, 2'b00, REV, 16'h2400});
      lfsr = nxt(lfsr);
      {gb, ga, ph} = lfsr;
      host.xfer(0, 2'b11, 5'h1F, {8'hFF, ph[9:8], ga, gb, ph[7:0], 8'hA5},
         fw);
      rd(2'b10, 5'h1E, {8'h00, ph[9:8], ga, gb, ph[7:0], 8'h00});
      rd(2'b00, 5'h1F, {24'h00_0000, 2'b00, REV});
      cw(10);
      chk(32'({gain_a_high, gain_b_high}), 32'({ga, gb}));
      repeat (16) begin
         lfsr = nxt(lfsr);
         sample_in = {lfsr, nxt(lfsr) ^ 16'h5A5A};
         ex = {corr(sample_in.i, sample_in.q, ph), sample_in.q};
         cw(1);
         chk(sample_out, ex);
      end
      host.xfer(0, 2'b00, 5'h17, 32'h0400_0000, fw);
      fw = 1;
      rd(2'b00, 5'h1E, {24'h00_0000, ph[9:8], ga, gb});
      chk(32'(host.tail), 32'h0000_0002);
      rd(2'b01, 5'h17, {16'h0000, 8'h04, 8'h00});
      dclk_run = 0;
      cw(4 * DCLK + 16);
      chk(32'({clock_alarm, output_muted}), 32'h0000_0003);
      chk(sample_out, 32'h0000_0000);
      dclk_run = 1;
      cw(20);
      chk(32'({clock_alarm, output_muted}), 32'h0000_0003);
      rd(2'b00, 5'h1F, {24'h00_0000, 2'b11, REV});
      host.xfer(0, 2'b00, 5'h1F, 32'h4000_0000, fw);
      cw(8);
      chk(32'({clock_alarm, output_muted}), 32'h0000_0001);
      host.xfer(0, 2'b00, 5'h1F, 32'h0000_0000, fw);
      cw(8);
      chk(32'({clock_alarm, output_muted}), 32'h0000_0000);
      stop_test;
   end
endmodule
bind scp_regs scp_regs_sva #(.DCLK_PERIOD_CLKS(DCLK_PERIOD_CLKS)) sva (
   .clk(clk), .srst(srst), .sclk(sclk), .serial_enable_n(serial_enable_n),
   .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
   .alarm_serial_out_pin_o(alarm_serial_out_pin_o),
   .alarm_serial_out_pin_oe(alarm_serial_out_pin_oe),
   .input_data_clock(input_data_clock), .sample_in(sample_in),
   .sample_out(sample_out), .gain_a_high(gain_a_high),
   .gain_b_high(gain_b_high), .output_muted(output_muted),
   .clock_alarm(clock_alarm));
